// >>> core/crf_ctrl.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module crf_ctrl
  import crf_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] port_power_enable,
  input  wire logic [1:0] threshold_hit,
  input  wire logic [1:0] overcurrent,
  input  wire logic [1:0] source_overvolt,
  input  wire logic [1:0] bus_undervolt,
  input  wire logic [1:0] back_voltage,
  input  wire logic [1:0] discharge_err,
  input  wire logic [1:0] cc_limiting,
  input  wire logic       first_thermal_limit,
  input  wire logic       upper_thermal_limit,
  output logic      [1:0] switch_close,
  output logic      [1:0] alert_n,
  output logic      [1:0] accum_run,
  output logic      [1:0] accum_clear,
  output logic      [1:0] monitor_en
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [7:0] ctl_ofs(input int idx);
    ctl_ofs = (idx == 0) ? CRF_CTL1_OFS : CRF_CTL2_OFS;
  endfunction

  function automatic logic [7:0] stat_ofs(input int idx);
    stat_ofs = (idx == 0) ? CRF_STAT1_OFS : CRF_STAT2_OFS;
  endfunction

  crf_state_t s_q;
  crf_state_t s_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    crf_port_t   pr;
    crf_port_t   nx;
    crf_pstate_t desired;
    logic        wr_ctl;
    logic        pen;
    logic        pen_rise;
    logic        pen_fall;
    logic        clr_pulse;
    logic        dis;
    logic        errclr;
    logic        sleep_force;
    logic        block;
    logic        ralert;
    logic        cond;
    logic        fault;
    pr          = '0;
    nx          = '0;
    desired     = CRF_ST_SLEEP;
    wr_ctl      = 1'b0;
    pen         = 1'b0;
    pen_rise    = 1'b0;
    pen_fall    = 1'b0;
    clr_pulse   = 1'b0;
    dis         = 1'b0;
    errclr      = 1'b0;
    sleep_force = 1'b0;
    block       = 1'b0;
    ralert      = 1'b0;
    cond        = 1'b0;
    fault       = 1'b0;
    s_d          = s_q;
    s_d.por_done = 1'b1;
    s_d.rdata    = 8'h00;

    if (reg_wr && reg_addr == CRF_CFG_OFS) begin
      s_d.latch = reg_wdata[CRF_CFG_LATCH_BIT];
    end

    for (int i = 0; i < 2; i++) begin
      pr       = s_q.port[i];
      nx       = pr;
      pen      = port_power_enable[i];
      pen_rise = pen & ~pr.pen_prev;
      pen_fall = ~pen & pr.pen_prev;
      nx.pen_prev = pen;
      desired  = pen ? CRF_ST_ACTIVE : CRF_ST_SLEEP;
      wr_ctl   = reg_wr && (reg_addr == ctl_ofs(i));
      errclr   = wr_ctl & reg_wdata[CRF_CTL_ERRCLR_BIT];
      dis      = wr_ctl & pr.en & ~reg_wdata[CRF_CTL_EN_BIT];

      // behaviour write alone never clears charge
      if (wr_ctl) begin
        nx.beh = crf_beh_t'(reg_wdata[CRF_CTL_BEH_LSB +: 2]);
        nx.en  = reg_wdata[CRF_CTL_EN_BIT];
      end

      clr_pulse = (wr_ctl & reg_wdata[CRF_CTL_CLR_BIT]) | dis;
      if (clr_pulse) begin
        nx.reached = 1'b0;
      end
      // threshold counts only while Active; set wins over clear
      if (threshold_hit[i] && pr.en && pr.state == CRF_ST_ACTIVE) begin
        nx.reached = 1'b1;
      end

      // Effects follow the live field, so a rewrite takes hold at once
      // behaviour decode
      sleep_force = pr.reached & (pr.beh == CRF_BEH_DISCSLP);
      // switch stays open on move to report and disconnect
      block  = pr.reached & ((pr.beh == CRF_BEH_REPDISC) | (pr.beh == CRF_BEH_DISCSLP));
      ralert = pr.reached & ((pr.beh == CRF_BEH_REPORT) | (pr.beh == CRF_BEH_REPDISC));

      // every keep-out except first thermal at enable rise or power-up enters here, undervoltage included
      cond = overcurrent[i] | source_overvolt[i] | bus_undervolt[i] | back_voltage[i]
           | discharge_err[i] | upper_thermal_limit
           | (first_thermal_limit & cc_limiting[i]);
      // first thermal qualified by CC, enable rise, power-up
      fault = (cond
            | (first_thermal_limit & pen_rise)
            | (first_thermal_limit & pen & ~s_q.por_done)) & ~sleep_force;

      case (pr.state)
        CRF_ST_SLEEP, CRF_ST_ACTIVE: begin
          if (sleep_force) begin
            nx.state = CRF_ST_SLEEP;
          end else if (fault) begin
            nx.state = CRF_ST_ERROR;
            nx.cnt   = 12'h000;
          end else begin
            nx.state = desired;
          end
        end
        CRF_ST_ERROR: begin
          if (sleep_force) begin
            nx.state = CRF_ST_SLEEP;
          end else if (s_q.latch) begin
            if ((pen_fall | errclr) && !cond) begin
              nx.state = desired;
            end
          end else if (pr.cnt >= CRF_RETRY_CYC - 12'h001) begin
            nx.cnt = 12'h000;
            if (!cond) begin
              nx.state = desired;
            end
          end else begin
            nx.cnt = pr.cnt + 12'h001;
          end
        end
        default: begin
          nx.state = CRF_ST_SLEEP;
        end
      endcase

      // Switch and alert are registered with the next state; run lags the state by one cycle
      nx.sw      = (nx.state == CRF_ST_ACTIVE) & ~block;
      nx.alert_n = ~(ralert | (nx.state == CRF_ST_ERROR));
      nx.run     = pr.en & (pr.state == CRF_ST_ACTIVE);
      nx.clr     = clr_pulse;
      nx.mon     = ~sleep_force;
      s_d.port[i] = nx;

      if (reg_rd && reg_addr == ctl_ofs(i)) begin
        s_d.rdata = {5'h00, pr.en, pr.beh};
      end
      if (reg_rd && reg_addr == stat_ofs(i)) begin
        s_d.rdata = {2'h0, ~pr.alert_n, pr.sw, pr.state, (pr.state == CRF_ST_ERROR), pr.reached};
      end
    end

    if (reg_rd && reg_addr == CRF_CFG_OFS) begin
      s_d.rdata = {7'h00, s_q.latch};
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.latch    <= CRF_LATCH_RST;
      for (int i = 0; i < 2; i++) begin
        s_q.port[i].state   <= CRF_ST_SLEEP;
        s_q.port[i].beh     <= CRF_BEH_RST;
        s_q.port[i].en      <= CRF_EN_RST;
        s_q.port[i].alert_n <= 1'b1;
        s_q.port[i].mon     <= 1'b1;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = s_q.rdata;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      switch_close[i] = s_q.port[i].sw;
      alert_n[i]      = s_q.port[i].alert_n;
      accum_run[i]    = s_q.port[i].run;
      accum_clear[i]  = s_q.port[i].clr;
      monitor_en[i]   = s_q.port[i].mon;
    end
  end

endmodule

// >>> core/crf_pkg.sv
package crf_pkg;

  // ****************************************************************
  // Register map, byte wide registers
  // ****************************************************************
  localparam logic [7:0] CRF_CFG_OFS   = 8'h00;
  localparam logic [7:0] CRF_CTL1_OFS  = 8'h01;
  localparam logic [7:0] CRF_CTL2_OFS  = 8'h02;
  localparam logic [7:0] CRF_STAT1_OFS = 8'h03;
  localparam logic [7:0] CRF_STAT2_OFS = 8'h04;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CRF_CFG_LATCH_BIT  = 0;
  localparam int CRF_CTL_BEH_LSB    = 0;
  localparam int CRF_CTL_EN_BIT     = 2;
  localparam int CRF_CTL_CLR_BIT    = 3;
  localparam int CRF_CTL_ERRCLR_BIT = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       CRF_LATCH_RST = 1'b0;
  localparam logic       CRF_EN_RST    = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CRF_CLK_PERIOD_PS = 5000;
  localparam int         CRF_T_CYCLE_NS    = 20000;
  localparam int         CRF_RETRY_CYC_I   = (CRF_T_CYCLE_NS * 1000 + CRF_CLK_PERIOD_PS - 1) / CRF_CLK_PERIOD_PS;
  localparam logic [11:0] CRF_RETRY_CYC    = CRF_RETRY_CYC_I[11:0];

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CRF_BEH_REPORT  = 2'h0,
    CRF_BEH_REPDISC = 2'h1,
    CRF_BEH_DISCSLP = 2'h2,
    CRF_BEH_IGNORE  = 2'h3
  } crf_beh_t;

  localparam crf_beh_t CRF_BEH_RST = CRF_BEH_REPDISC;

  // Gray along sleep, active, error
  typedef enum logic [1:0] {
    CRF_ST_SLEEP  = 2'h0,
    CRF_ST_ACTIVE = 2'h1,
    CRF_ST_ERROR  = 2'h3
  } crf_pstate_t;

  typedef struct packed {
    crf_pstate_t state;
    crf_beh_t    beh;
    logic        en;
    logic        reached;
    logic [11:0] cnt;
    logic        pen_prev;
    logic        sw;
    logic        alert_n;
    logic        run;
    logic        clr;
    logic        mon;
  } crf_port_t;

  typedef struct packed {
    crf_port_t [1:0] port;
    logic            latch;
    logic            por_done;
    logic [7:0]      rdata;
  } crf_state_t;

endpackage

// >>> tb/charge_reached_flag_a_fault_control_test.sv
`timescale 1ns/1ps
module charge_reached_flag_a_fault_control_test;
  import crf_pkg::*;
  logic       ref_clk;
  logic       arst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [1:0] pen;
  logic [1:0] th;
  logic [1:0] flt [5];
  logic [1:0] cc;
  logic       ft;
  logic       ut;
  logic [1:0] sw;
  logic [1:0] al;
  logic [1:0] run;
  logic [1:0] clr;
  logic [1:0] mon;
  logic       clr_seen;
  logic [7:0] d;
  int         miscompares;
  int         cmp_count;
  // Each entry: monitor, alert_n, switch of port 1, then behaviour
  logic [7:0] seq [11] = '{8'h1F, 8'h14, 8'h11, 8'h14, 8'h0A, 8'h11, 8'h0A, 8'h14, 8'h0A, 8'h1F, 8'h0A};
  // ****
  // Harness
  // ****
  crf_host h (.ref_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  crf_ctrl uut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_power_enable(pen), .threshold_hit(th), .overcurrent(flt[0]), .source_overvolt(flt[1]),
    .bus_undervolt(flt[2]), .back_voltage(flt[3]), .discharge_err(flt[4]), .cc_limiting(cc),
    .first_thermal_limit(ft), .upper_thermal_limit(ut), .switch_close(sw), .alert_n(al),
    .accum_run(run), .accum_clear(clr), .monitor_en(mon));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Sticky so a one-cycle pulse is never missed between looks
  always @(posedge ref_clk) if (clr[0] === 1'b1) clr_seen <= 1'b1;
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hit;
    th <= 2'h1;
    step(1);
    th <= 2'h0;
    step(4);
  endtask
  task automatic t_reached_flag_a;
    pen <= 2'h2;
    h.wr(CRF_CTL1_OFS, 8'h05);
    hit();
    h.rd(CRF_STAT1_OFS, d);
    chk("reached", d & 8'h01, 8'h00);
    pen <= 2'h3;
    step(4);
    chk("run", 8'(run), 8'h01);
    chk("sw", 8'(sw), 8'h03);
    hit();
    chk("sw", 8'(sw), 8'h02);
    chk("alert", 8'(al), 8'h02);
    clr_seen <= 1'b0;
    foreach (seq[i]) begin
      h.wr(CRF_CTL1_OFS, 8'h04 | seq[i] & 8'h03);
      step(4);
      chk("beh", 8'({mon[0], al[0], sw[0]}), seq[i] >> 2);
    end
    pen <= 2'h2;
    step(4);
    pen <= 2'h3;
    step(4);
    chk("lock", 8'({mon[0], sw[0]}), 8'h00);
    chk("clr", 8'(clr_seen), 8'h00);
    h.wr(CRF_CTL1_OFS, 8'h0E);
    step(4);
    chk("sw", 8'(sw), 8'h03);
    chk("clr", 8'(clr_seen), 8'h01);
    h.rd(CRF_STAT1_OFS, d);
    chk("reached", d & 8'h01, 8'h00);
    h.wr(CRF_CTL1_OFS, 8'h04);
    hit();
    chk("alert", 8'(al), 8'h02);
    h.wr(CRF_CTL1_OFS, 8'h00);
    clr_seen <= 1'b0;
    step(4);
    chk("alert", 8'(al), 8'h03);
    chk("clr", 8'(clr_seen), 8'h01);
    h.wr(CRF_CTL1_OFS, 8'h04);
    clr_seen <= 1'b0;
    h.wr(CRF_CTL1_OFS, 8'h00);
    step(4);
    chk("clr", 8'(clr_seen), 8'h01);
  endtask
  task automatic t_fault;
    h.wr(CRF_CFG_OFS, 8'h01);
    h.wr(CRF_CTL1_OFS, 8'h07);
    for (int i = 0; i < 5; i++) begin
      flt[i] <= 2'h1;
      step(4);
      chk("fault", 8'({al[0], sw[0]}), 8'h00);
      h.rd(CRF_STAT1_OFS, d);
      chk("state", d & 8'h0C, 8'h0C);
      flt[i] <= 2'h0;
      step(20);
      chk("latched", 8'(sw), 8'h02);
      h.wr(CRF_CTL1_OFS, 8'h17);
      step(4);
      chk("retest", 8'(sw), 8'h03);
    end
    ut <= 1'b1;
    step(4);
    chk("upper", 8'(sw), 8'h00);
    ut <= 1'b0;
    h.wr(CRF_CTL1_OFS, 8'h17);
    h.wr(CRF_CTL2_OFS, 8'h11);
    ft <= 1'b1;
    step(8);
    chk("warm", 8'(sw), 8'h03);
    cc <= 2'h1;
    step(4);
    chk("cc", 8'(sw), 8'h02);
    ft <= 1'b0;
    cc <= 2'h0;
    h.wr(CRF_CTL1_OFS, 8'h17);
    h.wr(CRF_CFG_OFS, 8'h00);
    flt[0] <= 2'h1;
    step(2);
    flt[0] <= 2'h0;
    step(4);
    chk("auto", 8'(sw), 8'h02);
    step(CRF_RETRY_CYC_I - 50);
    chk("wait", 8'(sw), 8'h02);
    step(100);
    chk("back", 8'({al[0], sw[0]}), 8'h03);
  endtask
  initial begin
    #100us;
    miscompares++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    pen = 2'h0;
    th = 2'h0;
    cc = 2'h0;
    ft = 1'b0;
    ut = 1'b0;
    foreach (flt[i]) flt[i] = 2'h0;
    clr_seen = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    step(10);
    arst_n <= 1'b1;
    step(2);
    chk("idle", 8'({mon, al}), 8'h0F);
    h.rd(CRF_CTL1_OFS, d);
    chk("ctl1", d, 8'h01);
    h.rd(CRF_CTL2_OFS, d);
    chk("ctl2", d, 8'h01);
    h.rd(CRF_CFG_OFS, d);
    chk("cfg", d, 8'h00);
    h.rd(8'h20, d);
    chk("unmapped", d, 8'h00);
    t_reached_flag_a();
    t_fault();
    conclude();
  end
endmodule

// >>> tb/crf_ctrl_asserts.sv
`timescale 1ns/1ps
module crf_ctrl_chk
  import crf_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       reg_wr,
  input wire logic [1:0] port_power_enable,
  input wire logic [1:0] overcurrent,
  input wire logic [1:0] cc_limiting,
  input wire logic       first_thermal_limit,
  input wire logic       upper_thermal_limit,
  input wire logic [1:0] switch_close,
  input wire logic [1:0] alert_n,
  input wire logic [1:0] accum_run,
  input wire logic [1:0] accum_clear,
  input wire logic [1:0] monitor_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ****
  // Port checks
  // ****
  a_clear_after_write: assert property (accum_clear[0] |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("clear pulse without a write");
  a_pen_low_opens: assert property (!port_power_enable[0] [*3] |-> !switch_close[0])
    else $error("switch closed with enable low");
  a_lock_open: assert property (!monitor_en[0] |-> !switch_close[0])
    else $error("switch closed while monitoring off");
  a_run_needs_pen: assert property (accum_run[0] |-> $past(port_power_enable[0]) || $past(port_power_enable[0], 2))
    else $error("accumulating outside active");
  a_fault_opens: assert property (overcurrent[0] && switch_close[0] |-> ##[1:3] (!switch_close[0] && !alert_n[0]))
    else $error("fault did not open port 1");
  a_port2_fault: assert property (overcurrent[1] && switch_close[1] |-> ##[1:3] (!switch_close[1] && !alert_n[1]))
    else $error("fault did not open port 2");
  a_upper_opens_both: assert property (upper_thermal_limit |-> ##[1:3] (switch_close == 2'h0))
    else $error("upper thermal left a switch closed");
  a_warm_cc_opens: assert property (first_thermal_limit && cc_limiting[0] && switch_close[0] |-> ##[1:3] !switch_close[0])
    else $error("warm limiting switch stayed closed");
endmodule
bind crf_ctrl crf_ctrl_chk u_chk (.ref_clk, .arst_n, .reg_wr, .port_power_enable, .overcurrent, .cc_limiting,
  .first_thermal_limit, .upper_thermal_limit, .switch_close, .alert_n, .accum_run, .accum_clear, .monitor_en);

// >>> tb/crf_host.sv
`timescale 1ns/1ps
module crf_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // ****
  // Host bus master
  // ****
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // register write, strobe held for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    q = reg_rdata;
  endtask
endmodule
